//--- tb/tb_top.sv
// Self-checking bench for the timer channel status and interrupt block
`timescale 1ns/100ps
`default_nettype none

module tb_top;

   // ==========================================================
   // Signals and live status bits
   localparam logic [31:0] CLK_B = 32'h1 << tcsi_pkg::BIT_CLOCK_ENABLED;
   localparam logic [31:0] LA_B = 32'h1 << tcsi_pkg::BIT_LINE_A_MIRROR;
   localparam logic [31:0] LB_B = 32'h1 << tcsi_pkg::BIT_LINE_B_MIRROR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, wave_mode;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [15:0] counter_value = 16'h0000;
   logic [15:0] value_a, value_b, value_c;
   logic count_step = 1'b0, overflow_evt = 1'b0, load_a_evt = 1'b0, load_b_evt = 1'b0;
   logic ext_trigger_evt = 1'b0, clock_enabled = 1'b0;
   logic line_a_io = 1'b0, line_b_io = 1'b1, line_a_drive = 1'b1, line_b_drive = 1'b0;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   int errors = 0;
   int checks_done = 0;

   // Clock at 10 MHz
   always #50 aclk = ~aclk;

   tcsi_channel dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .counter_value(counter_value), .count_step(count_step), .overflow_evt(overflow_evt),
      .load_a_evt(load_a_evt), .load_b_evt(load_b_evt), .ext_trigger_evt(ext_trigger_evt),
      .clock_enabled(clock_enabled), .line_a_io(line_a_io), .line_b_io(line_b_io),
      .line_a_drive(line_a_drive), .line_b_drive(line_b_drive), .irq(irq),
      .wave_mode(wave_mode), .value_a(value_a), .value_b(value_b), .value_c(value_c)
   );

   // ==========================================================
   // Verdict and comparison
   task automatic end_of_test;
      if (errors == 0 && checks_done > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // ==========================================================
   // Bus master tasks
   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!(bvalid && bready && !awvalid && !wvalid) && n < 100);
      if (n >= 100) errors++;
      check("write response", {30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask : wr

   // Read: address held until taken, data taken with rvalid
   task automatic rd_raw(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (!(rvalid && !arvalid) && n < 100);
      if (n >= 100) errors++;
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask : rd_raw

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rd_raw(a);
      check(nm, rd_data, exp);
      check("read response", {30'h0, rd_resp}, {30'h0, tcsi_pkg::RESP_OKAY});
   endtask : rd

   // ==========================================================
   // Event stimulus: {trigger, load b, load a, overflow} pulse, and counter steps
   task automatic ev(input logic [3:0] m, input logic [15:0] cv);
      @(posedge aclk);
      counter_value <= cv;
      {ext_trigger_evt, load_b_evt, load_a_evt, overflow_evt} <= m;
      @(posedge aclk);
      {ext_trigger_evt, load_b_evt, load_a_evt, overflow_evt} <= 4'h0;
   endtask : ev

   task automatic step(input logic [15:0] cv);
      @(posedge aclk);
      counter_value <= cv;
      count_step <= 1'b1;
      @(posedge aclk);
      count_step <= 1'b0;
   endtask : step

   // Watchdog cuts a hang short
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      end_of_test();
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and unmapped space
      rd("status reset", tcsi_pkg::OFF_STATUS, 32'h0);
      rd("value b reset", tcsi_pkg::OFF_VALUE_B, 32'h0);
      rd("value c reset", tcsi_pkg::OFF_VALUE_C, 32'h0);
      rd("mask reset", tcsi_pkg::OFF_IRQ_MASK, 32'h0);
      rd_raw(8'h3c);
      check("unmapped read resp", {30'h0, rd_resp}, {30'h0, tcsi_pkg::RESP_SLVERR});
      check("unmapped read data", rd_data, 32'h0);
      wr(8'h3c, 32'hffff_ffff, tcsi_pkg::RESP_SLVERR);
      // Value C always writable, upper half dropped
      wr(tcsi_pkg::OFF_VALUE_C, 32'h1234_abcd, tcsi_pkg::RESP_OKAY);
      rd("value c", tcsi_pkg::OFF_VALUE_C, 32'h0000_abcd);
      check("value c port", {16'h0, value_c}, 32'h0000_abcd);
      // Value B refuses writes in capture mode
      wr(tcsi_pkg::OFF_VALUE_B, 32'h0000_5555, tcsi_pkg::RESP_OKAY);
      rd("value b capture", tcsi_pkg::OFF_VALUE_B, 32'h0);
      // Mask set and clear
      wr(tcsi_pkg::OFF_IRQ_SET, 32'h0000_00a5, tcsi_pkg::RESP_OKAY);
      rd("mask set", tcsi_pkg::OFF_IRQ_MASK, 32'h0000_00a5);
      wr(tcsi_pkg::OFF_IRQ_SET, 32'h0000_000a, tcsi_pkg::RESP_OKAY);
      rd("mask set more", tcsi_pkg::OFF_IRQ_MASK, 32'h0000_00af);
      wr(tcsi_pkg::OFF_IRQ_CLEAR, 32'h0000_0005, tcsi_pkg::RESP_OKAY);
      rd("mask clear", tcsi_pkg::OFF_IRQ_MASK, 32'h0000_00aa);
      wr(tcsi_pkg::OFF_IRQ_CLEAR, 32'h0000_00ff, tcsi_pkg::RESP_OKAY);
      rd("mask empty", tcsi_pkg::OFF_IRQ_MASK, 32'h0);
      wr(tcsi_pkg::OFF_IRQ_SET, 32'h0000_00ff, tcsi_pkg::RESP_OKAY);
      // Waveform mode: compares, overflow and trigger; load flags stay clear
      wr(tcsi_pkg::OFF_MODE, 32'h0000_8000, tcsi_pkg::RESP_OKAY);
      check("wave mode", {31'h0, wave_mode}, 32'h1);
      rd("mode read", tcsi_pkg::OFF_MODE, 32'h0000_8000);
      clock_enabled <= 1'b1;
      wr(tcsi_pkg::OFF_VALUE_A, 32'h0000_0010, tcsi_pkg::RESP_OKAY);
      wr(tcsi_pkg::OFF_VALUE_B, 32'h0000_5555, tcsi_pkg::RESP_OKAY);
      rd("value b wave", tcsi_pkg::OFF_VALUE_B, 32'h0000_5555);
      check("value b port", {16'h0, value_b}, 32'h0000_5555);
      rd("status quiet", tcsi_pkg::OFF_STATUS, CLK_B | LA_B);
      check("irq quiet", {31'h0, irq}, 32'h0);
      step(16'h0010);
      step(16'h5555);
      step(16'habcd);
      ev(4'b1001, 16'h0001);
      ev(4'b0010, 16'h0002);
      ev(4'b0010, 16'h0003);
      @(posedge aclk);
      check("irq wave", {31'h0, irq}, 32'h1);
      rd("status wave", tcsi_pkg::OFF_STATUS, CLK_B | LA_B | 32'h9d);
      rd("status cleared", tcsi_pkg::OFF_STATUS, CLK_B | LA_B);
      check("irq cleared", {31'h0, irq}, 32'h0);
      // Capture mode: loads, overrun, compare C only
      wr(tcsi_pkg::OFF_MODE, 32'h0, tcsi_pkg::RESP_OKAY);
      check("capture mode", {31'h0, wave_mode}, 32'h0);
      clock_enabled <= 1'b0;
      ev(4'b0010, 16'h0777);
      ev(4'b0100, 16'h0888);
      ev(4'b0010, 16'h0999);
      step(16'habcd);
      step(16'h0999);
      step(16'h0888);
      check("value a port", {16'h0, value_a}, 32'h0000_0999);
      rd("status capture", tcsi_pkg::OFF_STATUS, LB_B | 32'h72);
      wr(tcsi_pkg::OFF_VALUE_B, 32'h0000_1111, tcsi_pkg::RESP_OKAY);
      rd("value b kept", tcsi_pkg::OFF_VALUE_B, 32'h0000_0888);
      rd("value a read", tcsi_pkg::OFF_VALUE_A, 32'h0000_0999);
      ev(4'b0010, 16'h0aaa);
      rd("status no overrun", tcsi_pkg::OFF_STATUS, LB_B | 32'h20);
      // Clock enable low: events are not taken and values stay put
      ce <= 1'b0;
      ev(4'b0011, 16'h0bbb);
      ce <= 1'b1;
      rd("status frozen", tcsi_pkg::OFF_STATUS, LB_B);
      check("value a frozen", {16'h0, value_a}, 32'h0000_0aaa);
      // Interrupt masked, then enabled, then cleared by status read
      wr(tcsi_pkg::OFF_IRQ_CLEAR, 32'h0000_00ff, tcsi_pkg::RESP_OKAY);
      ev(4'b1000, 16'h0000);
      @(posedge aclk);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(tcsi_pkg::OFF_IRQ_SET, 32'h0000_0080, tcsi_pkg::RESP_OKAY);
      check("irq enabled", {31'h0, irq}, 32'h1);
      rd("status trigger", tcsi_pkg::OFF_STATUS, LB_B | 32'h80);
      check("irq after read", {31'h0, irq}, 32'h0);
      end_of_test();
   end

endmodule : tb_top

`default_nettype wire

//--- verilog/tcsi_channel.sv
// Timer channel value registers, event flags, interrupt mask and bus slave
//
// How it works
// - Value B is writable only in waveform mode; capture mode ignores writes.
// - Value C is always readable and writable and reads back its held value.
// - Counter overflow sets bit 0; reading status clears it.
// - Capture mode: a second unread load of A or B sets load overrun.
// - Waveform mode: counter equal to A or B sets match A or B.
// - Counter equal to C sets match C in either mode.
// - Capture mode: loading A or B sets load A or load B.
// - An external trigger sets the trigger flag; status read clears it.
// - Status bit 16 shows live whether the counter clock is enabled.
// - Status bit 17 mirrors line A: pin level or driven level.
// - Status bit 18 mirrors line B: pin level or driven level.
// - Writing ones to the enable register sets those mask bits.
// - Writing ones to the disable register clears those mask bits.
// - The mask register reads back the mask in flag bit positions.
// - Mode select bit set means waveform mode, clear means capture mode.
`timescale 1ns/100ps
`default_nettype none

module tcsi_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [tcsi_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [tcsi_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tcsi_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [tcsi_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [tcsi_pkg::VAL_W-1:0] counter_value,
   input wire logic count_step,
   input wire logic overflow_evt,
   input wire logic load_a_evt,
   input wire logic load_b_evt,
   input wire logic ext_trigger_evt,
   input wire logic clock_enabled,
   input wire logic line_a_io,
   input wire logic line_b_io,
   input wire logic line_a_drive,
   input wire logic line_b_drive,
   output logic irq,
   output logic wave_mode,
   output logic [tcsi_pkg::VAL_W-1:0] value_a,
   output logic [tcsi_pkg::VAL_W-1:0] value_b,
   output logic [tcsi_pkg::VAL_W-1:0] value_c
);

   // ==========================================================
   // State record
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic [tcsi_pkg::ADDR_W-1:0] awaddr;
      logic w_held;
      logic [tcsi_pkg::DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [tcsi_pkg::DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic wave;
      logic [tcsi_pkg::VAL_W-1:0] value_a;
      logic [tcsi_pkg::VAL_W-1:0] value_b;
      logic [tcsi_pkg::VAL_W-1:0] value_c;
      logic [tcsi_pkg::FLAG_W-1:0] flags;
      logic [tcsi_pkg::FLAG_W-1:0] mask;
      logic a_unread;
      logic b_unread;
      logic line_a_meta;
      logic line_a_sync;
      logic line_b_meta;
      logic line_b_sync;
      logic irq;
   } tcsi_state_type;

   tcsi_state_type r;
   tcsi_state_type next_r;

   logic wr_go;
   logic ar_go;
   logic [tcsi_pkg::DATA_W-1:0] status_word;

   // ==========================================================
   // Byte lane merge for 16-bit values
   function automatic logic [tcsi_pkg::VAL_W-1:0] tcsi_merge(
      input logic [tcsi_pkg::VAL_W-1:0] old_val,
      input logic [tcsi_pkg::DATA_W-1:0] data,
      input logic [3:0] strb
   );
      logic [tcsi_pkg::VAL_W-1:0] res;
      res = old_val;
      if (strb[0])
      begin
         res[7:0] = data[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : tcsi_merge

   // ==========================================================
   // Handshake qualifiers
   assign wr_go = r.aw_held && r.w_held && !r.bvalid;
   assign ar_go = s_axi_arvalid && r.arready;

   // Live status word with sticky flags in the low byte
   always_comb
   begin
      status_word = '0;
      status_word[tcsi_pkg::FLAG_W-1:0] = r.flags;
      status_word[tcsi_pkg::BIT_CLOCK_ENABLED] = clock_enabled;
      status_word[tcsi_pkg::BIT_LINE_A_MIRROR] = r.wave ? line_a_drive : r.line_a_sync;
      status_word[tcsi_pkg::BIT_LINE_B_MIRROR] = r.wave ? line_b_drive : r.line_b_sync;
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      logic [tcsi_pkg::FLAG_W-1:0] set_flags;
      logic [tcsi_pkg::FLAG_W-1:0] clr_flags;
      logic read_a;
      logic read_b;
      next_r = r;
      set_flags = '0;
      clr_flags = '0;
      read_a = 1'b0;
      read_b = 1'b0;

      // Pin synchronisers
      next_r.line_a_meta = line_a_io;
      next_r.line_a_sync = r.line_a_meta;
      next_r.line_b_meta = line_b_io;
      next_r.line_b_sync = r.line_b_meta;

      // Write address and data are taken independently
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_held = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_held = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
      end

      // Register write, one cycle after both halves are held
      if (wr_go)
      begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = tcsi_pkg::RESP_OKAY;
         unique case (r.awaddr)
            tcsi_pkg::OFF_MODE:
            begin
               if (r.wstrb[1])
               begin
                  next_r.wave = r.wdata[tcsi_pkg::BIT_WAVE_MODE];
               end
            end
            tcsi_pkg::OFF_VALUE_A:
            begin
               if (r.wave)
               begin
                  next_r.value_a = tcsi_merge(r.value_a, r.wdata, r.wstrb);
               end
            end
            tcsi_pkg::OFF_VALUE_B:
            begin
               if (r.wave)
               begin
                  next_r.value_b = tcsi_merge(r.value_b, r.wdata, r.wstrb);
               end
            end
            tcsi_pkg::OFF_VALUE_C:
            begin
               next_r.value_c = tcsi_merge(r.value_c, r.wdata, r.wstrb);
            end
            tcsi_pkg::OFF_IRQ_SET:
            begin
               if (r.wstrb[0])
               begin
                  next_r.mask = r.mask | r.wdata[tcsi_pkg::FLAG_W-1:0];
               end
            end
            tcsi_pkg::OFF_IRQ_CLEAR:
            begin
               if (r.wstrb[0])
               begin
                  next_r.mask = r.mask & ~r.wdata[tcsi_pkg::FLAG_W-1:0];
               end
            end
            tcsi_pkg::OFF_STATUS, tcsi_pkg::OFF_IRQ_MASK:
            begin
               next_r.bresp = tcsi_pkg::RESP_OKAY;
            end
            default:
            begin
               next_r.bresp = tcsi_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Register read with its side effects
      if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
      end
      if (ar_go)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = tcsi_pkg::RESP_OKAY;
         next_r.rdata = '0;
         unique case (s_axi_araddr)
            tcsi_pkg::OFF_MODE:
            begin
               next_r.rdata[tcsi_pkg::BIT_WAVE_MODE] = r.wave;
            end
            tcsi_pkg::OFF_VALUE_A:
            begin
               next_r.rdata[tcsi_pkg::VAL_W-1:0] = r.value_a;
               read_a = 1'b1;
            end
            tcsi_pkg::OFF_VALUE_B:
            begin
               next_r.rdata[tcsi_pkg::VAL_W-1:0] = r.value_b;
               read_b = 1'b1;
            end
            tcsi_pkg::OFF_VALUE_C:
            begin
               next_r.rdata[tcsi_pkg::VAL_W-1:0] = r.value_c;
            end
            tcsi_pkg::OFF_STATUS:
            begin
               next_r.rdata = status_word;
               clr_flags = r.flags;
            end
            tcsi_pkg::OFF_IRQ_MASK:
            begin
               next_r.rdata[tcsi_pkg::FLAG_W-1:0] = r.mask;
            end
            tcsi_pkg::OFF_IRQ_SET, tcsi_pkg::OFF_IRQ_CLEAR:
            begin
               next_r.rresp = tcsi_pkg::RESP_OKAY;
            end
            default:
            begin
               next_r.rresp = tcsi_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Capture loads and unread tracking; a read clears before a load sets
      next_r.a_unread = r.a_unread && !read_a;
      next_r.b_unread = r.b_unread && !read_b;
      if (!r.wave && load_a_evt)
      begin
         next_r.value_a = counter_value;
         next_r.a_unread = 1'b1;
      end
      if (!r.wave && load_b_evt)
      begin
         next_r.value_b = counter_value;
         next_r.b_unread = 1'b1;
      end

      // Event detection
      set_flags[tcsi_pkg::BIT_OVERFLOW] = overflow_evt;
      set_flags[tcsi_pkg::BIT_LOAD_OVERRUN] = !r.wave
         && ((load_a_evt && r.a_unread && !read_a) || (load_b_evt && r.b_unread && !read_b));
      set_flags[tcsi_pkg::BIT_MATCH_A] = r.wave && count_step && (counter_value == r.value_a);
      set_flags[tcsi_pkg::BIT_MATCH_B] = r.wave && count_step && (counter_value == r.value_b);
      set_flags[tcsi_pkg::BIT_MATCH_C] = count_step && (counter_value == r.value_c);
      set_flags[tcsi_pkg::BIT_LOAD_A] = !r.wave && load_a_evt;
      set_flags[tcsi_pkg::BIT_LOAD_B] = !r.wave && load_b_evt;
      set_flags[tcsi_pkg::BIT_EXT_TRIGGER] = ext_trigger_evt;

      // Sticky flags: set wins over read clear, off-mode flags forced low
      next_r.flags = (r.flags & ~clr_flags) | set_flags;
      next_r.flags = next_r.flags & (next_r.wave ? tcsi_pkg::FLAGS_WAVE : tcsi_pkg::FLAGS_CAPTURE);
      next_r.a_unread = next_r.a_unread && !next_r.wave;  // Unread tracking idle in waveform mode
      next_r.b_unread = next_r.b_unread && !next_r.wave;

      // Interrupt level and ready signals follow the new state
      next_r.irq = |(next_r.flags & next_r.mask);
      next_r.awready = !next_r.aw_held && !next_r.bvalid;
      next_r.wready = !next_r.w_held && !next_r.bvalid;
      next_r.arready = !next_r.rvalid;
   end

   // ==========================================================
   // State register, frozen while ce is low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= '0;
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end

   // Outputs straight from the state record
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign irq = r.irq;
   assign wave_mode = r.wave;
   assign value_a = r.value_a;
   assign value_b = r.value_b;
   assign value_c = r.value_c;

   // ==========================================================
   // Assertions
   default clocking tcsi_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic sr_read;
   assign sr_read = ce && ar_go && (s_axi_araddr == tcsi_pkg::OFF_STATUS);

   value_b_locked_a: assert property (ce && wr_go && (r.awaddr == tcsi_pkg::OFF_VALUE_B) && !r.wave
      && !load_b_evt |=> $stable(r.value_b)) else $error("value B changed by write in capture mode");
   value_c_read_a: assert property (ce && ar_go && (s_axi_araddr == tcsi_pkg::OFF_VALUE_C)
      |=> s_axi_rvalid && (s_axi_rdata[15:0] == $past(r.value_c))) else $error("value C read mismatch");
   ovf_set_a: assert property (ce && overflow_evt |=> r.flags[tcsi_pkg::BIT_OVERFLOW])
      else $error("overflow flag not set");
   ovf_clear_a: assert property (sr_read && !overflow_evt |=> !r.flags[tcsi_pkg::BIT_OVERFLOW] ##1
      (!r.flags[tcsi_pkg::BIT_OVERFLOW] || $past(overflow_evt && ce))) else $error("overflow flag not cleared");
   overrun_mode_a: assert property (r.wave |-> !r.flags[tcsi_pkg::BIT_LOAD_OVERRUN]
      && !r.flags[tcsi_pkg::BIT_LOAD_A] && !r.flags[tcsi_pkg::BIT_LOAD_B]) else $error("capture flag in wave mode");
   match_a_set_a: assert property (ce && r.wave && count_step && (counter_value == r.value_a)
      |=> r.flags[tcsi_pkg::BIT_MATCH_A]) else $error("match A flag not set");
   match_b_set_a: assert property (ce && r.wave && count_step && (counter_value == r.value_b)
      |=> r.flags[tcsi_pkg::BIT_MATCH_B]) else $error("match B flag not set");
   match_c_set_a: assert property (ce && count_step && (counter_value == r.value_c)
      |=> r.flags[tcsi_pkg::BIT_MATCH_C]) else $error("match C flag not set");
   load_a_set_a: assert property (ce && !r.wave && load_a_evt |=> r.flags[tcsi_pkg::BIT_LOAD_A]
      && (r.value_a == $past(counter_value))) else $error("load A not recorded");
   trigger_set_a: assert property (ce && ext_trigger_evt |=> r.flags[tcsi_pkg::BIT_EXT_TRIGGER])
      else $error("trigger flag not set");
   clock_status_a: assert property (sr_read |=> s_axi_rdata[tcsi_pkg::BIT_CLOCK_ENABLED]
      == $past(clock_enabled)) else $error("clock status bit wrong");
   mirror_a_a: assert property (sr_read && r.wave |=> s_axi_rdata[tcsi_pkg::BIT_LINE_A_MIRROR]
      == $past(line_a_drive)) else $error("line A mirror wrong");
   mirror_b_a: assert property (ce && !r.wave ##1 ce && !r.wave ##1 sr_read && !r.wave
      |=> s_axi_rdata[tcsi_pkg::BIT_LINE_B_MIRROR] == $past(line_b_io, 3)) else $error("line B mirror wrong");
   mask_set_a: assert property (ce && wr_go && (r.awaddr == tcsi_pkg::OFF_IRQ_SET) && r.wstrb[0]
      |=> (r.mask & $past(r.wdata[7:0])) == $past(r.wdata[7:0])) else $error("mask bits not set");
   mask_clear_a: assert property (ce && wr_go && (r.awaddr == tcsi_pkg::OFF_IRQ_CLEAR) && r.wstrb[0]
      |=> (r.mask & $past(r.wdata[7:0])) == 8'h00) else $error("mask bits not cleared");
   mask_read_a: assert property (ce && ar_go && (s_axi_araddr == tcsi_pkg::OFF_IRQ_MASK)
      |=> s_axi_rdata[7:0] == $past(r.mask)) else $error("mask read mismatch");
   irq_level_a: assert property (irq == |(r.flags & r.mask)) else $error("interrupt level wrong");

   overrun_seen_c: cover property (r.flags[tcsi_pkg::BIT_LOAD_OVERRUN] ##[1:20] sr_read);
   irq_rise_c: cover property (!irq ##1 irq ##[1:20] sr_read);
   mode_switch_c: cover property (!r.wave ##1 r.wave);
   write_read_c: cover property (s_axi_bvalid && s_axi_bready ##[1:10] s_axi_rvalid && s_axi_rready);

endmodule : tcsi_channel

`default_nettype wire

//--- verilog/tcsi_pkg.sv
// Constants for the timer channel status and interrupt block
package tcsi_pkg;

   // ==========================================================
   // Bus and data widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VAL_W = 16;
   localparam int FLAG_W = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_VALUE_A = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_VALUE_B = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_VALUE_C = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_SET = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h2c;

   // ==========================================================
   // Event flag positions, shared by status, enable, disable and mask
   localparam int BIT_OVERFLOW = 0;
   localparam int BIT_LOAD_OVERRUN = 1;
   localparam int BIT_MATCH_A = 2;
   localparam int BIT_MATCH_B = 3;
   localparam int BIT_MATCH_C = 4;
   localparam int BIT_LOAD_A = 5;
   localparam int BIT_LOAD_B = 6;
   localparam int BIT_EXT_TRIGGER = 7;

   // Live status positions
   localparam int BIT_CLOCK_ENABLED = 16;
   localparam int BIT_LINE_A_MIRROR = 17;
   localparam int BIT_LINE_B_MIRROR = 18;

   // Mode select position in the mode register
   localparam int BIT_WAVE_MODE = 15;

   // Flags that may be set in each mode
   localparam logic [FLAG_W-1:0] FLAGS_WAVE = 8'h9d;
   localparam logic [FLAG_W-1:0] FLAGS_CAPTURE = 8'hf3;

   // ==========================================================
   // Reset values and responses
   localparam logic [VAL_W-1:0] VALUE_RESET = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcsi_pkg
